// File: rtl/parallel_poll_and_interrupt.sv
`timescale 1ns/100ps
module parallel_poll_and_interrupt
    import ppoll_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_exec_poll,
    input wire logic i_controller_active_wait_state,
    input wire logic i_controller_active_state,
    input wire logic i_command_sent,
    input wire logic [ppoll_pkg::DATA_W-1:0] i_dio,
    input wire logic i_identify,
    input wire logic i_remote_config,
    input wire logic i_cmd_valid,
    input wire logic [ppoll_pkg::DATA_W-1:0] i_cmd_byte,
    input wire logic i_cfg_disable,
    input wire logic i_cfg_sense,
    input wire logic [ppoll_pkg::SEL_W-1:0] i_response_line_select,
    input wire logic i_status_source_select,
    input wire logic i_set_poll,
    input wire logic i_clear_poll,
    input wire logic i_service_request_state,
    input wire logic i_srq_asserted,
    input wire logic i_three_state_sel,
    input wire logic [ppoll_pkg::STAT_W-1:0] i_events_one,
    input wire logic [ppoll_pkg::STAT_W-1:0] i_events_two,
    input wire logic [ppoll_pkg::STAT_W-1:0] i_interrupt_mask_one,
    input wire logic [ppoll_pkg::STAT_W-1:0] i_interrupt_mask_two,
    input wire logic i_read_status_one,
    input wire logic i_read_status_two,
    output logic o_identify,
    output logic o_poll_request,
    output logic [ppoll_pkg::DATA_W-1:0] o_command_pass_through_register,
    output logic o_command_out_flag,
    output logic [ppoll_pkg::DATA_W-1:0] o_dio_out,
    output logic [ppoll_pkg::DATA_W-1:0] o_dio_oe,
    output logic o_drive_mode_output,
    output logic [ppoll_pkg::STAT_W-1:0] o_interrupt_status_one,
    output logic [ppoll_pkg::STAT_W-1:0] o_interrupt_status_two,
    output logic o_irq
);
    import ppoll_pkg::*;

    poll_state_e state_q, state_d;
    logic rpp_q, rpp_d;
    logic idy_q, idy_d;
    logic [DATA_W-1:0] command_pass_through_register_q, command_pass_through_register_d;
    logic co_q, co_d;
    logic ist_q, ist_d;
    logic rem_en_q, rem_en_d;
    logic rem_sense_q, rem_sense_d;
    logic [SEL_W-1:0] rem_sel_q, rem_sel_d;
    logic [DATA_W-1:0] dout_q, dout_d;
    logic [DATA_W-1:0] doe_q, doe_d;
    logic drv_q, drv_d;
    logic [STAT_W-1:0] st1_q, st1_d, st2_q, st2_d;
    logic irq_q, irq_d;
    logic ctrl_active;
    logic ist_now;
    logic part_en, part_sense;
    logic [SEL_W-1:0] part_sel;
    logic resp_true;

    assign ctrl_active = i_controller_active_wait_state | i_controller_active_state;

    // Controller-side poll sequencing and response capture
    always_comb
    begin
        state_d = state_q;
        rpp_d = rpp_q;
        idy_d = 1'b0;
        command_pass_through_register_d = command_pass_through_register_q;
        co_d = co_q;
        if (i_exec_poll)
        begin
            rpp_d = 1'b1; // R1
            co_d = 1'b0;
        end
        case (state_q)
            POLL_IDLE:
            begin
                if (i_exec_poll | rpp_q)
                begin
                    state_d = POLL_WAIT;
                end
            end
            POLL_WAIT:
            begin
                if (ctrl_active)
                begin
                    idy_d = 1'b1; // R1
                    state_d = POLL_IDY;
                end
            end
            POLL_IDY:
            begin
                // Bus sampled one cycle after identify goes out so responders have settled
                command_pass_through_register_d = i_dio; // R2
                // An execute in the capture cycle keeps its request pending
                rpp_d = i_exec_poll; // R1 R2
                co_d = 1'b1; // R3
                state_d = POLL_IDLE;
            end
            default:
            begin
                state_d = POLL_IDLE;
            end
        endcase
        if (state_q != POLL_IDY && (i_command_sent || !ctrl_active))
        begin
            command_pass_through_register_d = COMMAND_PASS_THROUGH_REGISTER_RST; // R4
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_q <= POLL_IDLE;
            rpp_q <= 1'b0;
            idy_q <= 1'b0;
            command_pass_through_register_q <= COMMAND_PASS_THROUGH_REGISTER_RST;
            co_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rpp_q <= rpp_d;
            idy_q <= idy_d;
            command_pass_through_register_q <= command_pass_through_register_d;
            co_q <= co_d;
        end
    end

    // Configuration, individual status and poll response
    always_comb
    begin
        ist_d = ist_q;
        if (i_set_poll)
        begin
            ist_d = 1'b1; // R11
        end
        else if (i_clear_poll)
        begin
            ist_d = 1'b0; // R11
        end
        rem_en_d = rem_en_q;
        rem_sense_d = rem_sense_q;
        rem_sel_d = rem_sel_q;
        if (i_cmd_valid && i_cmd_byte[DATA_W-1:DATA_W-4] == PPE_HI)
        begin
            rem_en_d = 1'b1; // R8
            rem_sense_d = i_cmd_byte[CFG_SENSE_BIT];
            rem_sel_d = i_cmd_byte[SEL_W-1:0];
        end
        else if (i_cmd_valid && i_cmd_byte[DATA_W-1:DATA_W-4] == PPD_HI)
        begin
            rem_en_d = 1'b0; // R8
        end
        ist_now = i_status_source_select ? (i_service_request_state & i_srq_asserted) : ist_q; // R12
        part_en = i_remote_config ? rem_en_q : !i_cfg_disable; // R9
        part_sense = i_remote_config ? rem_sense_q : i_cfg_sense;
        part_sel = i_remote_config ? rem_sel_q : i_response_line_select;
        resp_true = (ist_now == part_sense); // R6
        // Open collector: only a true response enables a driver, false stays released
        dout_d = '0; // R7
        doe_d = '0;
        if (i_identify && part_en)
        begin
            doe_d[part_sel] = resp_true; // R5
            dout_d[part_sel] = resp_true;
        end
        drv_d = i_three_state_sel & !i_identify; // R16
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ist_q <= 1'b0;
            rem_en_q <= 1'b0;
            rem_sense_q <= 1'b0;
            rem_sel_q <= SEL_RST;
            dout_q <= '0;
            doe_q <= '0;
            drv_q <= 1'b0;
        end
        else
        begin
            ist_q <= ist_d;
            rem_en_q <= rem_en_d;
            rem_sense_q <= rem_sense_d;
            rem_sel_q <= rem_sel_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
            drv_q <= drv_d;
        end
    end

    // Interrupt status: read clears, but an event on the read cycle is kept
    always_comb
    begin
        st1_d = (i_read_status_one ? STAT_RST : st1_q) | i_events_one; // R14 R15
        st2_d = (i_read_status_two ? STAT_RST : st2_q) | i_events_two; // R14 R15
        irq_d = |(st1_d & i_interrupt_mask_one) | |(st2_d & i_interrupt_mask_two); // R13 R17
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st1_q <= STAT_RST;
            st2_q <= STAT_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            st1_q <= st1_d;
            st2_q <= st2_d;
            irq_q <= irq_d;
        end
    end

    assign o_identify = idy_q;
    assign o_poll_request = rpp_q;
    assign o_command_pass_through_register = command_pass_through_register_q;
    assign o_command_out_flag = co_q;
    assign o_dio_out = dout_q;
    assign o_dio_oe = doe_q;
    assign o_drive_mode_output = drv_q;
    assign o_interrupt_status_one = st1_q;
    assign o_interrupt_status_two = st2_q;
    assign o_irq = irq_q;
endmodule

// File: rtl/ppoll_pkg.sv
// Operation
// [R1] An execute-poll command sets the request-poll flag, and identify is sent only in controller active-wait or active state.
// [R2] When the poll executes, the eight data lines are latched into the pass-through register and the request-poll flag clears.
// [R3] The command-out flag is set to 1 when a controller-run parallel poll has finished.
// [R4] The captured response stays in the pass-through register until another command is sent or the controller goes inactive.
// [R5] While identify is asserted, a participating device drives only its one assigned line and leaves the other lines passive.
// [R6] The assigned line is driven true when the individual status equals the configured sense, and false otherwise.
// [R7] Poll responses are driven open-collector, so any true driver on a line wins over passive ones.
// [R8] Under remote configuration the device decodes enable and disable commands by itself to set participation, sense and line.
// [R9] Under local configuration participation, sense and line come from the disable bit, sense bit and line-select field.
// [R10] The controller configures each remote device in turn with unlisten, its listen address, then configure and enable or disable.
// The code sends no such sequence; it only decodes the enable and disable bytes it receives.
// [R11] With status-source select at zero, individual status changes only on the set-poll and clear-poll commands.
// [R12] With status-source select at one, individual status is true exactly while service is requested and SRQ is asserted.
// [R13] Each interrupt source is gated by its mask bit, and the request holds until the matching status register is read.
// [R14] Reading a status register clears all of its bits, and a still-present condition is not reported again by that read; events in the read cycle are kept.
// [R15] Status bits are recorded whether or not their mask bits are set.
// [R16] While being polled the drive-mode output is forced to open-collector even if three-state drive is selected.
// [R17] The interrupt request is the OR over both registers of each status bit ANDed with its mask bit.
package ppoll_pkg;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    localparam int STAT_W = 8;
    // Poll configuration command byte layout: 0110 S P3 P2 P1 enables, 0111 xxxx disables
    localparam logic [3:0] PPE_HI = 4'h6;
    localparam logic [3:0] PPD_HI = 4'h7;
    localparam int CFG_SENSE_BIT = 3;
    localparam logic [DATA_W-1:0] COMMAND_PASS_THROUGH_REGISTER_RST = 8'h00;
    localparam logic [STAT_W-1:0] STAT_RST = 8'h00;
    localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
    typedef enum logic [1:0] {POLL_IDLE, POLL_WAIT, POLL_IDY} poll_state_e;
endpackage

// File: testbench/bus_partner.sv
`timescale 1ns/100ps
module bus_partner
    import ppoll_pkg::*;
(
    input wire logic [DATA_W-1:0] i_others,
    input wire logic [DATA_W-1:0] i_dio_oe,
    output logic [DATA_W-1:0] o_dio
);
    // Open collector: any true driver wins, undriven lines stay passive false
    assign o_dio = i_others | i_dio_oe;
endmodule

// File: testbench/ppoll_asserts.sv
`timescale 1ns/100ps
module ppoll_asserts
    import ppoll_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_exec_poll,
    input wire logic i_controller_active_wait_state,
    input wire logic i_controller_active_state,
    input wire logic i_command_sent,
    input wire logic [DATA_W-1:0] i_dio,
    input wire logic i_identify,
    input wire logic o_identify,
    input wire logic o_poll_request,
    input wire logic [DATA_W-1:0] o_command_pass_through_register,
    input wire logic o_command_out_flag,
    input wire logic [DATA_W-1:0] o_dio_oe,
    input wire logic o_drive_mode_output
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    wire logic act = i_controller_active_wait_state || i_controller_active_state;
    a_exec_request: assert property (i_exec_poll |=> o_poll_request)
        else $error("no poll request");
    a_idy_active: assert property (o_identify |-> $past(act))
        else $error("identify while idle");
    a_capture_lines: assert property (o_identify && !i_exec_poll |=>
        o_command_pass_through_register == $past(i_dio) && o_command_out_flag && !o_poll_request)
        else $error("bad capture");
    a_capture_holds: assert property (!o_identify && !i_command_sent && act |=>
        $stable(o_command_pass_through_register)) else $error("capture lost");
    a_capture_clears: assert property ((i_command_sent || !act) && !o_identify |=>
        o_command_pass_through_register == COMMAND_PASS_THROUGH_REGISTER_RST) else $error("capture kept");
    a_one_line: assert property ($onehot0(o_dio_oe))
        else $error("several lines");
    a_idle_release: assert property (!i_identify |=> o_dio_oe == 8'h00)
        else $error("drives when idle");
    a_poll_collector: assert property (i_identify |=> !o_drive_mode_output)
        else $error("three-state in poll");
    c_capture: cover property (o_identify ##1 o_command_out_flag);
    c_respond: cover property (o_dio_oe != 8'h00);
    c_clear: cover property (i_command_sent ##1 !o_command_out_flag || act);
endmodule
bind parallel_poll_and_interrupt ppoll_asserts u_ppoll_asserts (.*);

// File: testbench/test_parallel_poll_and_interrupt.sv
`timescale 1ns/100ps
module test_parallel_poll_and_interrupt;
    import ppoll_pkg::*;
    bit i_clk, i_rst = 1, i_exec_poll, i_controller_active_wait_state, i_controller_active_state;
    bit i_command_sent, i_identify, i_remote_config, i_cmd_valid, i_cfg_disable, i_cfg_sense;
    bit i_status_source_select, i_set_poll, i_clear_poll, i_service_request_state;
    bit i_srq_asserted, i_three_state_sel = 1, i_read_status_one, i_read_status_two;
    bit [SEL_W-1:0] i_response_line_select;
    bit [DATA_W-1:0] i_cmd_byte, i_events_one, i_events_two, i_interrupt_mask_one;
    bit [DATA_W-1:0] i_interrupt_mask_two, others = 8'h24;
    logic [DATA_W-1:0] i_dio, o_command_pass_through_register, o_dio_out, o_dio_oe;
    logic [STAT_W-1:0] o_interrupt_status_one, o_interrupt_status_two;
    logic o_identify, o_poll_request, o_command_out_flag, o_drive_mode_output, o_irq;
    int err_total, cmp_count, cyc;
    initial forever #50 i_clk = ~i_clk;
    parallel_poll_and_interrupt u_parallel_poll_and_interrupt (.*);
    bus_partner u_bus_partner (.i_others(others), .i_dio_oe(o_dio_oe), .o_dio(i_dio));
    task tick;
        @(posedge i_clk);
        #5;
        if (++cyc == 3000)
            final_report('1);
    endtask
    task chk(input logic [16:0] got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp)
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        err_total += int'(got !== exp);
    endtask
    task final_report(input bit hung);
        err_total += hung;
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic pulse(ref bit s);
        s = '1;
        tick;
        s = '0;
    endtask
    task respond(input logic [DATA_W-1:0] exp);
        i_identify = '1;
        repeat (2) tick;
        chk(o_dio_oe, exp);
        chk({o_drive_mode_output, o_dio_out}, {1'b0, exp});
        i_identify = '0;
        tick;
        chk({o_drive_mode_output, o_dio_oe}, 17'h100);
    endtask
    initial
    begin
        repeat (4) tick;
        i_rst = '0;
        pulse(i_exec_poll);
        chk({o_poll_request, o_command_out_flag}, 17'h2);
        tick;
        chk(o_identify, 17'h0);
        i_controller_active_wait_state = '1;
        repeat (8) if (o_identify !== 1'h1) tick;
        tick;
        chk({o_command_out_flag, o_poll_request, o_command_pass_through_register}, 17'h224);
        pulse(i_command_sent);
        chk(o_command_pass_through_register, 17'h0);
        pulse(i_exec_poll);
        tick;
        // Execute again in the capture cycle: the new request must survive
        pulse(i_exec_poll);
        chk({o_poll_request, o_command_out_flag}, 17'h3);
        chk(o_command_pass_through_register, 17'h24);
        i_controller_active_wait_state = '0;
        tick;
        chk({o_identify, o_command_pass_through_register}, 17'h0);
        i_status_source_select = '1;
        for (int k = 0; k < 64; k++)
        begin
            {i_service_request_state, i_cfg_sense} = k[5:4];
            {i_srq_asserted, i_response_line_select} = k[3:0];
            respond((i_service_request_state & i_srq_asserted) == i_cfg_sense ?
                8'h01 << i_response_line_select : 8'h00);
        end
        i_status_source_select = '0;
        pulse(i_set_poll);
        i_srq_asserted = '0;
        respond(8'h80);
        pulse(i_clear_poll);
        respond(8'h00);
        i_remote_config = '1;
        i_cmd_byte = 8'h65;
        pulse(i_cmd_valid);
        respond(8'h20);
        i_cmd_byte = 8'h70;
        pulse(i_cmd_valid);
        respond(8'h00);
        {i_remote_config, i_cfg_disable, i_cfg_sense} = 3'h2;
        respond(8'h00);
        {i_interrupt_mask_one, i_events_one, i_events_two} = 24'h018110;
        tick;
        // A new event in the read cycle must survive the clear
        {i_read_status_one, i_events_one, i_events_two} = {1'h1, 8'h02, 8'h00};
        chk({o_irq, o_interrupt_status_one, o_interrupt_status_two}, 17'h18110);
        tick;
        {i_read_status_one, i_events_one, i_interrupt_mask_two} = {1'h0, 8'h00, 8'h10};
        chk({o_irq, o_interrupt_status_one, o_interrupt_status_two}, 17'h00210);
        tick;
        chk(o_irq, 17'h1);
        pulse(i_read_status_two);
        chk({o_irq, o_interrupt_status_one, o_interrupt_status_two}, 17'h00200);
        final_report('0);
    end
endmodule
